// ===== hdl/usb_host_ep_defines.svh
// Offsets, field positions, reset values and sizes of the host endpoints
`ifndef USB_HOST_EP_DEFINES_SVH
`define USB_HOST_EP_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_EP_MODE 12'h000
`define OFS_RX_BASE 12'h004
`define OFS_TX_BASE 12'h008
`define OFS_AUX_SETUP 12'h00c
`define OFS_TOKEN 12'h010
`define OFS_RX_CTRL 12'h014
`define OFS_TX_LEN 12'h018
`define OFS_TX_CTRL 12'h01c
`define OFS_RX_LEN 12'h020

// ****************************************
// Field positions
// ****************************************
`define BIT_TX_EN 6
`define BIT_TX_DUAL 4
`define BIT_RX_EN 3
`define BIT_RX_DUAL 0
`define BIT_PRE_EN 7
`define BIT_SOF_EN 6
`define BIT_RX_TOG 7
`define BIT_RX_AUTO 4
`define BIT_RX_NOHS 2
`define BIT_TX_TOG 6
`define BIT_TX_AUTO 4
`define BIT_TX_NOHS 0

// ****************************************
// Write masks, sizes and reset values
// ****************************************
`define MASK_EP_MODE 8'h59
`define MASK_AUX 8'hc0
`define MASK_RX_CTRL 8'h94
`define MASK_TX_CTRL 8'h51
`define ADDR_VALID_MASK 16'h7fff
`define BUF_BYTES 15'h0040
`define RESET_BYTE 8'h00
`define RESET_BASE 16'h0000

`endif

// ===== hdl/usb_host_ep_pkg.sv
// Types shared by the host endpoint block
package usb_host_ep_pkg;
    typedef enum logic [1:0] {
        DPID_DATA0,
        DPID_DATA1
    } data_pid_t;

    typedef enum logic [1:0] {
        HS_ACK,
        HS_NONE
    } handshake_t;

    typedef enum logic [1:0] {
        AHB_IDLE = 2'b00,
        AHB_BUSY = 2'b01,
        AHB_NONSEQ = 2'b10,
        AHB_SEQ = 2'b11
    } htrans_t;
endpackage

// ===== hdl/usb_host_endpoint_buffer_ctrl.sv
// AHB-Lite register block and buffer steering for the USB host endpoints
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "usb_host_ep_defines.svh"

module usb_host_endpoint_buffer_ctrl #(
    parameter int ADDR_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire usb_host_ep_pkg::htrans_t htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Engine side: transaction progress from the serial engine
    input wire logic rx_data_ok,
    input wire logic [7:0] rx_count,
    input wire logic tx_data_ok,
    input wire logic rx_byte_valid,
    input wire logic [5:0] rx_byte_index,
    input wire logic tx_byte_req,
    input wire logic [5:0] tx_byte_index,
    // Buffer memory strobe and address outputs
    output logic rx_mem_we,
    output logic [14:0] rx_mem_addr,
    output logic tx_mem_re,
    output logic [14:0] tx_mem_addr,
    // Protocol settings toward the engine
    output logic [3:0] token_pid_field,
    output logic [3:0] target_endpoint_field,
    output logic lowspeed_preamble_enable,
    output logic auto_frame_start_enable,
    output logic [7:0] tx_byte_count,
    output usb_host_ep_pkg::data_pid_t rx_expected_pid,
    output usb_host_ep_pkg::data_pid_t tx_data_pid,
    output usb_host_ep_pkg::handshake_t rx_handshake,
    output usb_host_ep_pkg::handshake_t tx_expected_handshake,
    output logic rx_endpoint_enable,
    output logic tx_endpoint_enable
);
    import usb_host_ep_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [14:0] buf_addr(input logic [15:0] base,
                                             input logic dual,
                                             input logic tog,
                                             input logic [5:0] idx);
        logic [14:0] b;
        b = base[14:0];
        if (dual && tog) begin
            b = b + `BUF_BYTES;
        end
        buf_addr = b + {9'h000, idx};
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wr,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wr & mask);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ep_mode_r;
    logic [15:0] rx_base_r;
    logic [15:0] tx_base_r;
    logic [7:0] aux_r;
    logic [7:0] token_r;
    logic [7:0] rx_ctrl_r;
    logic [7:0] tx_len_r;
    logic [7:0] tx_ctrl_r;
    logic [7:0] rx_len_r;
    logic wr_pend_r;
    logic [ADDR_W-1:0] wr_addr_r;

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic addr_phase = hsel && hready && htrans[1];
    wire logic wr_now = wr_pend_r;
    wire logic [ADDR_W-1:0] ra = haddr;
    wire logic [7:0] wb = hwdata[7:0];
    wire logic wr_mode = wr_now && wr_addr_r == `OFS_EP_MODE;
    wire logic wr_rxb = wr_now && wr_addr_r == `OFS_RX_BASE;
    wire logic wr_txb = wr_now && wr_addr_r == `OFS_TX_BASE;
    wire logic wr_aux = wr_now && wr_addr_r == `OFS_AUX_SETUP;
    wire logic wr_tok = wr_now && wr_addr_r == `OFS_TOKEN;
    wire logic wr_rxc = wr_now && wr_addr_r == `OFS_RX_CTRL;
    wire logic wr_txl = wr_now && wr_addr_r == `OFS_TX_LEN;
    wire logic wr_txc = wr_now && wr_addr_r == `OFS_TX_CTRL;

    wire logic rx_en = ep_mode_r[`BIT_RX_EN];
    wire logic tx_en = ep_mode_r[`BIT_TX_EN];
    wire logic rx_tog = rx_ctrl_r[`BIT_RX_TOG];
    wire logic tx_tog = tx_ctrl_r[`BIT_TX_TOG];
    // Flips only when the engine reports success and the endpoint is live
    wire logic rx_flip = rx_data_ok && rx_en && rx_ctrl_r[`BIT_RX_AUTO];
    wire logic tx_flip = tx_data_ok && tx_en && tx_ctrl_r[`BIT_TX_AUTO];

    // Hardware flip is applied after a same-cycle software write
    wire logic [7:0] rx_ctrl_w = wr_rxc ? merge(rx_ctrl_r, wb, `MASK_RX_CTRL)
                                        : rx_ctrl_r;
    wire logic [7:0] tx_ctrl_w = wr_txc ? merge(tx_ctrl_r, wb, `MASK_TX_CTRL)
                                        : tx_ctrl_r;
    wire logic [7:0] rx_ctrl_nxt = rx_ctrl_w ^ {rx_flip, 7'h00};
    wire logic [7:0] tx_ctrl_nxt = tx_ctrl_w ^ {1'b0, tx_flip, 6'h00};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= addr_phase && hwrite;
            wr_addr_r <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ep_mode_r <= `RESET_BYTE;
            rx_base_r <= `RESET_BASE;
            tx_base_r <= `RESET_BASE;
            aux_r <= `RESET_BYTE;
            token_r <= `RESET_BYTE;
            rx_ctrl_r <= `RESET_BYTE;
            tx_len_r <= `RESET_BYTE;
            tx_ctrl_r <= `RESET_BYTE;
            rx_len_r <= `RESET_BYTE;
        end else begin
            if (wr_mode) begin
                ep_mode_r <= merge(ep_mode_r, wb, `MASK_EP_MODE);
            end
            if (wr_rxb) begin
                rx_base_r <= hwdata[15:0];
            end
            if (wr_txb) begin
                tx_base_r <= hwdata[15:0];
            end
            if (wr_aux) begin
                aux_r <= merge(aux_r, wb, `MASK_AUX);
            end
            if (wr_tok) begin
                token_r <= wb;
            end
            if (wr_txl) begin
                tx_len_r <= wb;
            end
            if (rx_data_ok && rx_en) begin
                rx_len_r <= rx_count;
            end
            rx_ctrl_r <= rx_ctrl_nxt;
            tx_ctrl_r <= tx_ctrl_nxt;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (ra)
            `OFS_EP_MODE: rdata_nxt = {24'h000000, ep_mode_r};
            `OFS_RX_BASE: rdata_nxt = {16'h0000, rx_base_r};
            `OFS_TX_BASE: rdata_nxt = {16'h0000, tx_base_r};
            `OFS_AUX_SETUP: rdata_nxt = {24'h000000, aux_r};
            `OFS_TOKEN: rdata_nxt = {24'h000000, token_r};
            `OFS_RX_CTRL: rdata_nxt = {24'h000000, rx_ctrl_r};
            `OFS_TX_LEN: rdata_nxt = {24'h000000, tx_len_r};
            `OFS_TX_CTRL: rdata_nxt = {24'h000000, tx_ctrl_r};
            `OFS_RX_LEN: rdata_nxt = {24'h000000, rx_len_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // Zero wait states; unmapped addresses still answer OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************
    // Buffer steering
    // ****************************************
    wire logic [14:0] rx_addr_c = buf_addr(rx_base_r & `ADDR_VALID_MASK,
        ep_mode_r[`BIT_RX_DUAL], rx_tog,
        rx_byte_index);
    wire logic [14:0] tx_addr_c = buf_addr(tx_base_r & `ADDR_VALID_MASK,
        ep_mode_r[`BIT_TX_DUAL], tx_tog, tx_byte_index);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_mem_we <= 1'b0;
            rx_mem_addr <= 15'h0000;
            tx_mem_re <= 1'b0;
            tx_mem_addr <= 15'h0000;
        end else begin
            rx_mem_we <= rx_byte_valid && rx_en;
            rx_mem_addr <= rx_en ? rx_addr_c : 15'h0000;
            tx_mem_re <= tx_byte_req && tx_en
                && {2'b00, tx_byte_index} < tx_len_r;
            tx_mem_addr <= tx_en ? tx_addr_c : 15'h0000;
        end
    end

    // ****************************************
    // Protocol settings
    // ****************************************
    assign token_pid_field = token_r[7:4];
    assign target_endpoint_field = token_r[3:0];
    assign lowspeed_preamble_enable = aux_r[`BIT_PRE_EN];
    assign auto_frame_start_enable = aux_r[`BIT_SOF_EN];
    assign tx_byte_count = tx_len_r;
    assign rx_expected_pid = rx_tog ? DPID_DATA1 : DPID_DATA0;
    assign tx_data_pid = tx_tog ? DPID_DATA1 : DPID_DATA0;
    assign rx_handshake = rx_ctrl_r[`BIT_RX_NOHS] ? HS_NONE : HS_ACK;
    assign tx_expected_handshake =
        tx_ctrl_r[`BIT_TX_NOHS] ? HS_NONE : HS_ACK;
    assign rx_endpoint_enable = rx_en;
    assign tx_endpoint_enable = tx_en;

    // ****************************************
    // Checks
    // ****************************************
    a_rx_no_access: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(rx_en) |-> !rx_mem_we)
        else $error("receive buffer written while endpoint disabled");
    a_rx_dual_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(rx_en && ep_mode_r[0] && rx_tog) && $past(rx_byte_index) == 0
        |-> rx_mem_addr == $past(rx_base_r[14:0]) + 15'h0040)
        else $error("dual receive buffer select wrong");
    a_rx_single: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(rx_en && !ep_mode_r[0]) |->
        rx_mem_addr == $past(rx_base_r[14:0]) + {9'h000, $past(rx_byte_index)})
        else $error("single receive address wrong");
    a_tx_dual_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(tx_en && ep_mode_r[4] && !tx_tog) |->
        tx_mem_addr == $past(tx_base_r[14:0]) + {9'h000, $past(tx_byte_index)})
        else $error("first transmit buffer select wrong");
    a_rx_auto_flip: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_flip && !wr_rxc |=> rx_tog != $past(rx_tog))
        else $error("receive toggle did not flip");
    a_rx_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !rx_flip && !wr_rxc |=> $stable(rx_tog))
        else $error("receive toggle changed unprompted");
    a_tx_auto_flip: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_flip && !wr_txc |=> tx_tog != $past(tx_tog))
        else $error("transmit toggle did not flip");
    a_tx_len_cap: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_mem_re |-> {2'b00, $past(tx_byte_index)} < $past(tx_len_r))
        else $error("transmit fetch beyond length");
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (ep_mode_r & ~8'h59) == 0 && (rx_ctrl_r & ~8'h94) == 0
        && (tx_ctrl_r & ~8'h51) == 0 && aux_r[5:0] == 0)
        else $error("reserved bit set");
    a_rx_len_rec: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_data_ok && rx_en |=> rx_len_r == $past(rx_count))
        else $error("receive count not recorded");
endmodule

// ===== testbench/usb_engine_model.sv
// Behavioural serial engine and attached device feeding the endpoint block
`timescale 1ns/1ps

module usb_engine_model (
    input wire logic hclk,
    output logic rx_data_ok,
    output logic [7:0] rx_count,
    output logic tx_data_ok,
    output logic rx_byte_valid,
    output logic [5:0] rx_byte_index,
    output logic tx_byte_req,
    output logic [5:0] tx_byte_index
);
    initial begin
        {rx_data_ok, tx_data_ok, rx_byte_valid, tx_byte_req} = 4'h0;
        {rx_count, rx_byte_index, tx_byte_index} = 20'h0;
    end

    // Random stall before each event, as a slow device on the bus causes
    task automatic pulse(input int kind, input logic [7:0] v);
        repeat ($urandom_range(3, 0)) @(posedge hclk);
        @(posedge hclk);
        case (kind)
            0: {rx_byte_valid, rx_byte_index} <= {1'b1, v[5:0]};
            1: {tx_byte_req, tx_byte_index} <= {1'b1, v[5:0]};
            2: {rx_data_ok, rx_count} <= {1'b1, v};
            default: tx_data_ok <= 1'b1;
        endcase
        @(posedge hclk);
        {rx_data_ok, tx_data_ok, rx_byte_valid, tx_byte_req} <= 4'h0;
        // Stale qualifiers are scrambled so nothing can lean on them
        {rx_count, rx_byte_index, tx_byte_index} <= ~{v, v[5:0], v[5:0]};
    endtask
endmodule

// ===== testbench/usb_host_endpoint_buffer_ctrl_tb_top.sv
// Self-checking bench for the host endpoint register and buffer block
`timescale 1ns/1ps

module usb_host_endpoint_buffer_ctrl_tb_top;
    import usb_host_ep_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    htrans_t htrans = AHB_IDLE;
    logic [31:0] hrdata;
    logic hreadyout, hresp, rx_data_ok, tx_data_ok, rx_byte_valid;
    logic tx_byte_req, rx_mem_we, tx_mem_re;
    logic lowspeed_preamble_enable, auto_frame_start_enable;
    logic rx_endpoint_enable, tx_endpoint_enable;
    logic [7:0] rx_count, tx_byte_count;
    logic [5:0] rx_byte_index, tx_byte_index;
    logic [14:0] rx_mem_addr, tx_mem_addr;
    logic [3:0] token_pid_field, target_endpoint_field;
    data_pid_t rx_expected_pid, tx_data_pid;
    handshake_t rx_handshake, tx_expected_handshake;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int m[9] = '{default: 0};
    int mask[9] = '{32'h59, 32'hffff, 32'hffff, 32'hc0, 32'hff, 32'h94,
        32'hff, 32'h51, 32'h0};

    usb_host_endpoint_buffer_ctrl usb_host_endpoint_buffer_ctrl_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_data_ok,
        .rx_count, .tx_data_ok, .rx_byte_valid, .rx_byte_index,
        .tx_byte_req, .tx_byte_index, .rx_mem_we, .rx_mem_addr, .tx_mem_re,
        .tx_mem_addr, .token_pid_field, .target_endpoint_field,
        .lowspeed_preamble_enable, .auto_frame_start_enable, .tx_byte_count,
        .rx_expected_pid, .tx_data_pid, .rx_handshake,
        .tx_expected_handshake, .rx_endpoint_enable, .tx_endpoint_enable);

    usb_engine_model usb_engine_model_inst (
        .hclk, .rx_data_ok, .rx_count, .tx_data_ok, .rx_byte_valid,
        .rx_byte_index, .tx_byte_req, .tx_byte_index);

    always #5 hclk = ~hclk;

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Limit sits well above the roughly 3000 cycles the tests need
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Called at a rising edge; returns at the edge that ends the data phase
    task automatic bus(input logic wr, input int a, input int d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        hwrite <= wr;
        haddr <= a[11:0];
        htrans <= AHB_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= AHB_IDLE;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic rd(input int a);
        logic [31:0] q;
        bus(1'b0, a, 0, q);
        check(q, (a >> 2) < 9 ? m[a >> 2] : 0);
        check(hresp, 0);
    endtask

    task automatic wr(input int a, input int d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        if ((a >> 2) < 8) m[a >> 2] = d & mask[a >> 2];
    endtask

    task automatic out_check();
        check({token_pid_field, target_endpoint_field}, m[4]);
        check({lowspeed_preamble_enable, auto_frame_start_enable},
              m[3] >> 6);
        check(tx_byte_count, m[6]);
        check(rx_expected_pid, m[5][7]);
        check(rx_handshake, m[5][2]);
        check(tx_data_pid, m[7][6]);
        check(tx_expected_handshake, m[7][0]);
        check({tx_endpoint_enable, rx_endpoint_enable},
              {m[0][6], m[0][3]});
    endtask

    // Sends one byte event and counts memory strobes on the next two cycles
    task automatic byte_event(input int kind, input int idx);
        int cnt;
        int en;
        int exp;
        logic [14:0] got;
        cnt = 0;
        got = 15'h0000;
        usb_engine_model_inst.pulse(kind, idx[7:0]);
        repeat (2) begin
            @(negedge hclk);
            if ((kind == 0 ? rx_mem_we : tx_mem_re) === 1'b1) begin
                cnt++;
                got = kind == 0 ? rx_mem_addr : tx_mem_addr;
            end
        end
        if (kind == 0) begin
            en = m[0][3];
            exp = (m[1] & 32'h7fff) + ((m[0][0] & m[5][7]) ? 64 : 0) + idx;
        end else begin
            en = m[0][6] && idx < m[6];
            exp = (m[2] & 32'h7fff) + ((m[0][4] & m[7][6]) ? 64 : 0) + idx;
        end
        check(cnt, en);
        if (en) check(got, exp & 32'h7fff);
        @(posedge hclk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int v;
        void'($urandom(32'ha31b));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 40; a += 4) rd(a);
        out_check();
        for (int it = 0; it < 48; it++) begin
            for (int a = 0; a < 40; a += 4) begin
                v = $urandom;
                if (a == 4 || a == 8) v &= ~32'h3;
                if (a == 24) v = $urandom_range(80, 0);
                wr(a, v);
            end
            for (int a = 0; a < 40; a += 4) rd(a);
            out_check();
            byte_event(0, $urandom_range(63, 0));
            byte_event(1, $urandom_range(63, 0));
            if (m[0][3]) begin
                v = $urandom_range(64, 0);
                usb_engine_model_inst.pulse(2, v[7:0]);
                m[8] = v;
                if (m[5][4]) m[5][7] = !m[5][7];
            end
            if (m[0][6]) begin
                usb_engine_model_inst.pulse(3, 8'h00);
                if (m[7][4]) m[7][6] = !m[7][6];
            end
            repeat (2) @(posedge hclk);
            rd(20);
            rd(28);
            rd(32);
            out_check();
        end
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        m = '{default: 0};
        for (int a = 0; a < 40; a += 4) rd(a);
        out_check();
        results();
    end
endmodule
